// ### hdl/sac_osc.sv
// Internal conversion oscillator: a free-running divider giving a one-cycle tick.
// Assumes ref_clk is the only clock and clk_en gates all state.
`timescale 1ns/10ps
`include "sac_regs.svh"

module sac_osc #(
  parameter int DIV = `SAC_OSC_DIV_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  output logic tick
);

  localparam int CW = $clog2(DIV);

  generate
    if (DIV < 2) begin : g_bad_div
      $error("sac_osc: DIV must be at least 2");
    end
  endgenerate

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic tick_q;
  logic tick_d;

  always_comb begin
    cnt_d = cnt_q;
    tick_d = 1'b0;
    if (cnt_q == CW'(DIV - 1)) begin
      cnt_d = '0;
      tick_d = 1'b1;
    end else begin
      cnt_d = cnt_q + CW'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (clk_en) begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

endmodule

// ### hdl/sac_outdrv.sv
// Result line drivers: decodes the live read controls into data and enables.
// Assumes busy and result are the next-cycle values of the sequencer flops.
`timescale 1ns/10ps
`include "sac_regs.svh"

module sac_outdrv (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input sac_pkg::sac_ctrl_s ctrl,
  input wire logic busy,
  input wire logic [`SAC_RES_W-1:0] result,
  output sac_pkg::sac_bus_s bus
);

  sac_pkg::sac_bus_s bus_q;
  sac_pkg::sac_bus_s bus_d;
  sac_pkg::sac_bus_s want;
  logic read_en;

  // Only the live levels are used here; nothing is latched.
  assign read_en = ctrl.rd_conv && !busy && ctrl.chip_en && !ctrl.chip_sel_n;

  always_comb begin
    want.data = '0;
    want.oe = '0;
    if (read_en) begin
      if (ctrl.word_wide) begin
        want.data = result;
        want.oe = '1;
      end else if (!ctrl.half_select) begin
        want.data[11:4] = result[11:4];
        want.oe[11:4] = 8'hFF;
      end else begin
        want.data[3:0] = result[3:0];
        want.data[7:4] = 4'h0;
        want.oe[7:0] = 8'hFF;
      end
    end
  end

  // A change from one enabled set to another passes through one cycle with all
  // drivers off, so strapped byte lanes never fight.
  always_comb begin
    bus_d = want;
    if ((bus_q.oe != '0) && (want.oe != '0) && (want.oe != bus_q.oe)) begin
      bus_d.oe = '0;
      bus_d.data = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      bus_q <= '0;
    end else if (clk_en) begin
      bus_q <= bus_d;
    end
  end

  assign bus = bus_q;

endmodule

// ### hdl/sac_pkg.sv
// Types shared by the converter control block.
// Assumes sac_regs.svh is on the include path.
`include "sac_regs.svh"

package sac_pkg;

  typedef enum logic [1:0] {
    SAC_IDLE,
    SAC_ACQ,
    SAC_CONV
  } sac_state_e;

  typedef struct packed {
    logic chip_en;
    logic chip_sel_n;
    logic rd_conv;
    logic word_wide;
    logic half_select;
  } sac_ctrl_s;

  typedef struct packed {
    logic [`SAC_RES_W-1:0] data;
    logic [`SAC_RES_W-1:0] oe;
  } sac_bus_s;

endpackage

// ### hdl/sac_regs.svh
// Constants of the converter control block: widths, counts and timing figures.
// Assumes inclusion by bare name from files under hdl/.
`ifndef SAC_REGS_SVH
`define SAC_REGS_SVH

`define SAC_RES_W 12
`define SAC_MSB_IDX 4'hB
`define SAC_LSB_IDX 4'h0
`define SAC_SHORT_STOP_IDX 4'h4
`define SAC_SHORT_FILL 4'h8
`define SAC_ACQ_TICKS 2
`define SAC_CLK_PERIOD_NS 8
`define SAC_OSC_PERIOD_NS 725
`define SAC_OSC_DIV_CYC (`SAC_OSC_PERIOD_NS / `SAC_CLK_PERIOD_NS)
`define SAC_SETUP_NS 50
`define SAC_SETUP_CYC ((`SAC_SETUP_NS + `SAC_CLK_PERIOD_NS - 1) / `SAC_CLK_PERIOD_NS)

`endif

// ### hdl/sac_top.sv
// Control logic of a 12-bit successive-approximation converter: start decode,
// conversion sequencer, status and result line drivers.
// Assumes all inputs are synchronous to ref_clk and an external comparator
// answers the trial code on dac_code within one oscillator period.
`timescale 1ns/10ps
`include "sac_regs.svh"

module sac_top #(
  parameter int OSC_DIV = `SAC_OSC_DIV_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input sac_pkg::sac_ctrl_s ctrl,
  input wire logic comp_above,
  output logic [`SAC_RES_W-1:0] dac_code,
  output logic hold_sample,
  output logic conv_in_progress,
  output sac_pkg::sac_bus_s result_lines
);

  localparam logic [1:0] ACQ_LAST = 2'(`SAC_ACQ_TICKS - 1);

  generate
    if (`SAC_ACQ_TICKS < 1 || `SAC_ACQ_TICKS > 4) begin : g_bad_acq
      $error("sac_top: acquisition count out of range");
    end
  endgenerate

  logic osc_tick;
  logic start_cond;
  logic start_evt;
  logic start_prev_q;
  logic start_prev_d;

  sac_pkg::sac_state_e state_q;
  sac_pkg::sac_state_e state_d;
  logic [1:0] acq_cnt_q;
  logic [1:0] acq_cnt_d;
  logic [3:0] bit_idx_q;
  logic [3:0] bit_idx_d;
  logic [`SAC_RES_W-1:0] trial_q;
  logic [`SAC_RES_W-1:0] trial_d;
  logic [`SAC_RES_W-1:0] result_q;
  logic [`SAC_RES_W-1:0] result_d;
  logic short_q;
  logic short_d;
  logic busy_q;
  logic busy_d;
  logic hold_q;
  logic hold_d;
  logic [3:0] stop_idx;

  sac_osc #(
    .DIV(OSC_DIV)
  ) u_osc (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .tick(osc_tick)
  );

  // The three start inputs meet in one AND term, so whichever arrives last
  // completes it and every path sees the same one-edge detection delay.
  assign start_cond = ctrl.chip_en && !ctrl.chip_sel_n && !ctrl.rd_conv;
  assign start_evt = start_cond && !start_prev_q;

  always_comb begin
    start_prev_d = start_cond;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      start_prev_q <= 1'b0;
    end else if (clk_en) begin
      start_prev_q <= start_prev_d;
    end
  end

  // A short conversion stops after the fifth-lowest bit.
  assign stop_idx = short_q ? `SAC_SHORT_STOP_IDX : `SAC_LSB_IDX;

  always_comb begin
    state_d = state_q;
    acq_cnt_d = acq_cnt_q;
    bit_idx_d = bit_idx_q;
    trial_d = trial_q;
    result_d = result_q;
    short_d = short_q;
    busy_d = busy_q;
    hold_d = hold_q;
    unique case (state_q)
      sac_pkg::SAC_IDLE: begin
        if (start_evt) begin
          state_d = sac_pkg::SAC_ACQ;
          short_d = ctrl.half_select;
          busy_d = 1'b1;
          hold_d = 1'b0;
          acq_cnt_d = 2'h0;
          trial_d = '0;
        end
      end
      sac_pkg::SAC_ACQ: begin
        // A repeated start only refreshes the length select.
        if (start_evt) begin
          short_d = ctrl.half_select;
        end
        if (osc_tick) begin
          if (acq_cnt_q == ACQ_LAST) begin
            state_d = sac_pkg::SAC_CONV;
            hold_d = 1'b1;
            bit_idx_d = `SAC_MSB_IDX;
            trial_d = '0;
            trial_d[`SAC_MSB_IDX] = 1'b1;
          end else begin
            acq_cnt_d = acq_cnt_q + 2'h1;
          end
        end
      end
      sac_pkg::SAC_CONV: begin
        if (start_evt) begin
          short_d = ctrl.half_select;
        end
        if (osc_tick) begin
          trial_d[bit_idx_q] = comp_above;
          if (bit_idx_q <= stop_idx) begin
            state_d = sac_pkg::SAC_IDLE;
            busy_d = 1'b0;
            hold_d = 1'b0;
            result_d = trial_d;
            if (short_q) begin
              result_d[3:0] = `SAC_SHORT_FILL;
            end
          end else begin
            bit_idx_d = bit_idx_q - 4'h1;
            trial_d[bit_idx_q - 4'h1] = 1'b1;
          end
        end
      end
    endcase
    // The length select cannot change to short once the conversion has passed its short stop bit.
    if (state_q == sac_pkg::SAC_CONV && start_evt && ctrl.half_select &&
        bit_idx_q < `SAC_SHORT_STOP_IDX) begin
      short_d = short_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_q <= sac_pkg::SAC_IDLE;
      acq_cnt_q <= 2'h0;
      bit_idx_q <= 4'h0;
      trial_q <= '0;
      result_q <= '0;
      short_q <= 1'b0;
      busy_q <= 1'b0;
      hold_q <= 1'b0;
    end else if (clk_en) begin
      state_q <= state_d;
      acq_cnt_q <= acq_cnt_d;
      bit_idx_q <= bit_idx_d;
      trial_q <= trial_d;
      result_q <= result_d;
      short_q <= short_d;
      busy_q <= busy_d;
      hold_q <= hold_d;
    end
  end

  // The driver stage sees the next status and result, so its enables drop in
  // the very edge on which status rises.
  sac_outdrv u_outdrv (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .ctrl(ctrl),
    .busy(busy_d),
    .result(result_d),
    .bus(result_lines)
  );

  assign dac_code = trial_q;
  assign hold_sample = hold_q;
  assign conv_in_progress = busy_q;

endmodule

// ### verif/sac_chk.sv
// Port checker for the converter control block.
// Assumes it is bound into sac_top and sees only its ports.
`timescale 1ns/10ps
`include "sac_regs.svh"
module sac_chk #(
  parameter int OSC_DIV = `SAC_OSC_DIV_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input sac_pkg::sac_ctrl_s ctrl,
  input wire logic comp_above,
  input wire logic [`SAC_RES_W-1:0] dac_code,
  input wire logic hold_sample,
  input wire logic conv_in_progress,
  input sac_pkg::sac_bus_s result_lines
);
  // Worst case is fourteen ticks; the bound adds two divider periods of slack.
  localparam int MAX_CONV = 16 * OSC_DIV;
  wire en = ctrl.chip_en && !ctrl.chip_sel_n;
  wire st = en && !ctrl.rd_conv;
  wire rd = en && ctrl.rd_conv;
  wire [11:0] oe = result_lines.oe;
  // Busy cycles are counted here, not in a delay range, so the bound stays usable
  // at the full oscillator divider.
  int busy_cyc;
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !conv_in_progress) begin
      busy_cyc <= 0;
    end else if (clk_en) begin
      busy_cyc <= busy_cyc + 1;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_start;
    clk_en && st && !$past(st) && !conv_in_progress |=> conv_in_progress;
  endproperty
  a_start: assert property (p_start) else $error("start missed");
  property p_none;
    !conv_in_progress && !en |=> !conv_in_progress;
  endproperty
  a_none: assert property (p_none) else $error("start while disabled");
  property p_busy;
    conv_in_progress |-> oe == 12'h000;
  endproperty
  a_busy: assert property (p_busy) else $error("drivers on while busy");
  property p_gate;
    !rd |=> oe == 12'h000;
  endproperty
  a_gate: assert property (p_gate) else $error("drivers on without read");
  property p_wide;
    (rd && ctrl.word_wide) [*2] ##1 !conv_in_progress |-> oe == 12'hFFF;
  endproperty
  a_wide: assert property (p_wide) else $error("wide enables wrong");
  property p_msb;
    (rd && !ctrl.word_wide && !ctrl.half_select) [*2] ##1 !conv_in_progress |-> oe == 12'hFF0;
  endproperty
  a_msb: assert property (p_msb) else $error("upper byte enables wrong");
  property p_lsb;
    (rd && !ctrl.word_wide && ctrl.half_select) [*2] ##1 !conv_in_progress
      |-> oe == 12'h0FF && result_lines.data[7:4] == 4'h0;
  endproperty
  a_lsb: assert property (p_lsb) else $error("lower byte wrong");
  property p_bbm;
    oe != 12'h000 && $past(oe) != 12'h000 |-> oe == $past(oe);
  endproperty
  a_bbm: assert property (p_bbm) else $error("bytes overlap");
  property p_len;
    conv_in_progress |-> busy_cyc <= MAX_CONV;
  endproperty
  a_len: assert property (p_len) else $error("conversion too long");
  property p_fell;
    $fell(hold_sample) |-> $fell(conv_in_progress);
  endproperty
  a_fell: assert property (p_fell) else $error("conversion restarted");
  property p_hold;
    $rose(hold_sample) |-> conv_in_progress && dac_code == 12'h800;
  endproperty
  a_hold: assert property (p_hold) else $error("hold without first trial code");
endmodule
bind sac_top sac_chk #(.OSC_DIV(OSC_DIV)) sac_chk_i (.ref_clk, .rst_n, .clk_en, .ctrl,
  .comp_above, .dac_code, .hold_sample, .conv_in_progress, .result_lines);

// ### verif/sac_cmp_model.sv
// Comparator standing in for the analog side of the converter.
// Assumes vin is the analog input expressed as an ideal code.
`timescale 1ns/10ps
`include "sac_regs.svh"
module sac_cmp_model (
  input wire logic ref_clk,
  input wire logic hold_sample,
  input wire logic [`SAC_RES_W-1:0] vin,
  input wire logic [`SAC_RES_W-1:0] dac_code,
  output logic comp_above
);
  logic [`SAC_RES_W-1:0] samp_q;
  // The input is tracked until hold, so later input changes cannot leak in.
  always_ff @(posedge ref_clk) if (!hold_sample) samp_q <= vin;
  assign comp_above = (samp_q >= dac_code);
endmodule

// ### verif/sac_top_tb.sv
// Self-checking bench for sac_top with a comparator model.
// Assumes a short oscillator divider to keep conversions brief.
`timescale 1ns/10ps
`include "sac_regs.svh"
module sac_top_tb;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  sac_pkg::sac_ctrl_s ctrl = 5'h00;
  logic [11:0] vin = 12'h000;
  logic [15:0] lfsr = 16'h0009;
  logic comp_above;
  logic [11:0] dac_code;
  logic hold_sample;
  logic conv_in_progress;
  sac_pkg::sac_bus_s result_lines;
  logic [23:0] exp_q[$];
  logic [11:0] prev_oe = 12'hFFF;
  logic [23:0] mon_seen;
  logic [23:0] mon_want;
  int miscompares = 0;
  int samples_checked = 0;
  initial forever #4 ref_clk = ~ref_clk;
  sac_top #(.OSC_DIV(4)) sac_top_i (.ref_clk, .rst_n, .clk_en, .ctrl, .comp_above,
    .dac_code, .hold_sample, .conv_in_progress, .result_lines);
  sac_cmp_model sac_cmp_model_i (.ref_clk, .hold_sample, .vin, .dac_code, .comp_above);
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check(input logic [23:0] seen, input logic [23:0] want);
    samples_checked++;
    if (seen !== want) begin
      miscompares++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic print_verdict;
    $display("checked=%0d miscompares=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic put(input logic [4:0] c);
    @(posedge ref_clk);
    ctrl <= c;
  endtask
  task automatic wait_stat(input logic lvl);
    int n;
    n = 0;
    while (conv_in_progress !== lvl && n < 300) begin
      @(negedge ref_clk);
      n++;
    end
    if (conv_in_progress !== lvl) begin
      miscompares++;
      print_verdict();
    end
  endtask
  // One start input is held off while the other two settle, then it fires.
  // Holding off the convert line leaves a live read of the previous result.
  task automatic conv(input int trig, input logic [4:0] start, input logic [11:0] prev);
    lfsr = lfsr_next(lfsr);
    if (trig == 2) begin
      if (start[1]) exp_q.push_back({prev, 12'hFFF});
      else if (!start[0]) exp_q.push_back({prev[11:4], 4'h0, 12'hFF0});
      else exp_q.push_back({8'h00, prev[3:0], 12'h0FF});
    end
    put(start ^ (5'h10 >> trig));
    vin <= lfsr[11:0];
    repeat (7) @(posedge ref_clk);
    ctrl <= start;
    wait_stat(1'b1);
    wait_stat(1'b0);
  endtask
  task automatic rd(input logic [1:0] mode, input logic [23:0] want);
    exp_q.push_back(want);
    put({3'b101, mode});
    repeat (3) @(posedge ref_clk);
  endtask
  // Floating lines are masked so only driven bits are compared.
  always @(negedge ref_clk) begin
    if (result_lines.oe !== 12'h000 && prev_oe === 12'h000) begin
      mon_seen = {result_lines.data & result_lines.oe, result_lines.oe};
      mon_want = exp_q.size() > 0 ? exp_q.pop_front() : {24{1'bx}};
      check(mon_seen, mon_want);
    end
    prev_oe = result_lines.oe;
  end
  initial begin
    logic [11:0] r;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      conv(i % 3, {3'b100, i == 2, i[0]}, r);
      r = i[0] ? {vin[11:4], 4'h8} : vin;
      rd(2'b10, {r, 12'hFFF});
      rd(2'b00, {r[11:4], 4'h0, 12'hFF0});
      rd(2'b01, {8'h00, r[3:0], 12'h0FF});
      put(5'h00);
      repeat (2) @(posedge ref_clk);
    end
    // Enabled but deselected first, then selected with enable dropped: neither may start.
    put(5'h18);
    repeat (4) @(posedge ref_clk);
    put(5'h00);
    repeat (20) @(negedge ref_clk);
    check({23'h0, conv_in_progress}, 24'h000000);
    check(24'(exp_q.size()), 24'h000000);
    print_verdict();
  end
endmodule
